//--- design/qsc_pkg.sv
// qsc_pkg: register map, field positions, reset values and shared types
// of the queued serial master sequencer.
// assumes a 16-bit register port with byte-style offsets in steps of four.
package qsc_pkg;

    // ==========================================================
    // register offsets
    localparam logic [7:0] OFS_DLY      = 8'h00;
    localparam logic [7:0] OFS_WRAP     = 8'h04;
    localparam logic [7:0] OFS_IRQ      = 8'h08;
    localparam logic [7:0] OFS_TXD      = 8'h0c;
    localparam logic [7:0] OFS_RXD      = 8'h10;
    localparam logic [7:0] OFS_CMD_BASE = 8'h40;

    // ==========================================================
    // field positions
    localparam int POS_RUN       = 15;
    localparam int POS_LEAD_LO   = 8;
    localparam int POS_HALT      = 15;
    localparam int POS_WRAP_EN   = 14;
    localparam int POS_WRAP_TGT  = 13;
    localparam int POS_CS_IDLE   = 12;
    localparam int POS_END_LO    = 8;
    localparam int POS_DONE_LO   = 4;
    localparam int POS_LOCKOUT   = 12;
    localparam int POS_ABORT     = 2;
    localparam int POS_FINISHED  = 0;
    localparam int POS_TX_FULL   = 8;

    // ==========================================================
    // reset values and timing
    localparam logic [15:0] RST_DLY   = 16'h0000;
    localparam logic [15:0] RST_WRAP  = 16'h0000;
    localparam logic [7:0]  DLY_DEF   = 8'h01;
    localparam logic [3:0]  SCK_HALF_CYC = 4'h4;
    localparam logic [5:0]  SCK_EDGES = 6'h20;
    localparam int          TX_DEPTH  = 16;
    localparam int          WORD_W    = 16;

    typedef struct packed {
        logic       post_delay_select;
        logic       clk_delay_select;
        logic [3:0] cs;
    } qsc_cmd_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } qsc_bus_t;

endpackage

//--- design/qsc_fifo.sv
// qsc_fifo: synchronous word FIFO, width and depth as parameters.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module qsc_fifo
    import qsc_pkg::*;
#(
    parameter int W = 16,
    parameter int D = 16
)
(
    input  wire logic         core_clk_i,
    input  wire logic         srst_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem_r [D];
    logic [AW:0]  wptr_r;
    logic [AW:0]  rptr_r;
    logic         push;
    logic         pop;

    // extra pointer bit separates full from empty
    assign in_ready_o  = !((wptr_r[AW] != rptr_r[AW]) && (wptr_r[AW-1:0] == rptr_r[AW-1:0]));
    assign out_valid_o = (wptr_r != rptr_r);
    assign out_data_o  = mem_r[rptr_r[AW-1:0]];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge core_clk_i)
    begin
        if (push)
        begin
            mem_r[wptr_r[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            wptr_r <= '0;
            rptr_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wptr_r <= wptr_r + 1'b1;
            end
            if (pop)
            begin
                rptr_r <= rptr_r + 1'b1;
            end
        end
    end
endmodule // qsc_fifo
`default_nettype wire

//--- design/qsc_seq.sv
// qsc_seq: queued serial master sequencer with command RAM, delays,
// queue pointers, wraparound, halt and abort handling.
// assumes a register master on core_clk_i and a miso pin from outside.
`timescale 1ns/1ps
`default_nettype none
module qsc_seq
    import qsc_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        srst_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic [15:0]      reg_rdata_o,
    input  wire logic        miso_i,
    output logic             sck_o,
    output logic             mosi_o,
    output logic [3:0]       cs_o
);
    // ==========================================================
    // declarations
    typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_LEAD, ST_SHIFT, ST_POST} qsc_state_t;

    qsc_state_t  st_r;
    qsc_bus_t    bus;
    qsc_cmd_t    cmd_ram_r [16];
    qsc_cmd_t    cur_cmd;
    logic        run_r;
    logic [6:0]  lead_r;
    logic [7:0]  post_r;
    logic        halt_r;
    logic        wrap_en_r;
    logic        wrap_tgt_r;
    logic        cs_idle_r;
    logic [3:0]  end_ptr_r;
    logic [3:0]  done_ptr_r;
    logic [3:0]  start_ptr_r;
    logic        lockout_r;
    logic        abort_flag_r;
    logic        fin_flag_r;
    logic [3:0]  ptr_r;
    logic [7:0]  dly_cnt_r;
    logic [3:0]  half_cnt_r;
    logic [5:0]  edge_cnt_r;
    logic [15:0] sh_r;
    logic [15:0] rx_word_r;
    logic        rx_bit_r;
    logic        sck_r;
    logic        mosi_r;
    logic [3:0]  cs_r;
    logic [15:0] rdata_r;
    logic        miso_m_r;
    logic        miso_s_r;
    logic        wr_dly;
    logic        wr_wrap;
    logic        wr_irq;
    logic        wr_txd;
    logic        wr_cmd;
    logic        sw_set_run;
    logic        sw_clr_run;
    logic        abort_evt;
    logic        post_done;
    logic        at_end;
    logic        seq_end;
    logic        tx_ready;
    logic        tx_valid;
    logic        tx_pop;
    logic [15:0] tx_data;
    logic [7:0]  lead_load;
    logic [7:0]  post_load;

    assign bus     = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i, wdata: reg_wdata_i};
    assign wr_dly  = bus.wr && (bus.addr == OFS_DLY);
    assign wr_wrap = bus.wr && (bus.addr == OFS_WRAP);
    assign wr_irq  = bus.wr && (bus.addr == OFS_IRQ);
    assign wr_txd  = bus.wr && (bus.addr == OFS_TXD);
    assign wr_cmd  = bus.wr && (bus.addr[7:6] == OFS_CMD_BASE[7:6]) && (bus.addr[1:0] == 2'b00);
    assign cur_cmd = cmd_ram_r[ptr_r];

    assign sw_set_run = wr_dly && bus.wdata[POS_RUN];
    assign sw_clr_run = wr_dly && !bus.wdata[POS_RUN] && !lockout_r;
    assign abort_evt  = sw_clr_run && run_r;
    assign post_done  = (st_r == ST_POST) && (dly_cnt_r <= 8'h01);
    assign at_end     = (ptr_r == end_ptr_r);
    assign seq_end    = post_done && (halt_r || (at_end && !wrap_en_r));
    assign tx_pop     = (st_r == ST_LOAD) && tx_valid && !abort_evt;
    // a zero delay field still costs one cycle so the counter never underflows
    assign lead_load  = (cur_cmd.clk_delay_select && (lead_r != 7'h00)) ? {1'b0, lead_r} : DLY_DEF;
    assign post_load  = (cur_cmd.post_delay_select && (post_r != 8'h00)) ? post_r : DLY_DEF;

    // ==========================================================
    // transmit word buffer; a full buffer drops the write, software polls
    qsc_fifo #(
        .W (WORD_W),
        .D (TX_DEPTH)
    ) u_txq (
        .core_clk_i  (core_clk_i),
        .srst_i      (srst_i),
        .in_valid_i  (wr_txd),
        .in_ready_o  (tx_ready),
        .in_data_i   (bus.wdata),
        .out_valid_o (tx_valid),
        .out_ready_i (tx_pop),
        .out_data_o  (tx_data)
    );

    // ==========================================================
    // registers
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            lead_r <= RST_DLY[14:8];
            post_r <= RST_DLY[7:0];
        end
        else if (wr_dly)
        begin
            lead_r <= bus.wdata[14:POS_LEAD_LO];
            post_r <= bus.wdata[7:0];
        end
    end

    // software set wins over a completion in the same cycle
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            run_r <= RST_DLY[POS_RUN];
        end
        else if (sw_set_run)
        begin
            run_r <= 1'b1;
        end
        else if (sw_clr_run)
        begin
            run_r <= 1'b0;
        end
        else if (seq_end)
        begin
            run_r <= 1'b0;
        end
    end

    // done pointer is not in the write path at all
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            halt_r      <= RST_WRAP[POS_HALT];
            wrap_en_r   <= RST_WRAP[POS_WRAP_EN];
            wrap_tgt_r  <= RST_WRAP[POS_WRAP_TGT];
            cs_idle_r   <= RST_WRAP[POS_CS_IDLE];
            end_ptr_r   <= RST_WRAP[11:8];
            start_ptr_r <= RST_WRAP[3:0];
        end
        else if (wr_wrap)
        begin
            halt_r      <= bus.wdata[POS_HALT];
            wrap_en_r   <= bus.wdata[POS_WRAP_EN];
            wrap_tgt_r  <= bus.wdata[POS_WRAP_TGT];
            cs_idle_r   <= bus.wdata[POS_CS_IDLE];
            end_ptr_r   <= bus.wdata[11:POS_END_LO];
            start_ptr_r <= bus.wdata[3:0];
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            lockout_r    <= 1'b0;
            abort_flag_r <= 1'b0;
            fin_flag_r   <= 1'b0;
        end
        else
        begin
            if (wr_irq)
            begin
                lockout_r <= bus.wdata[POS_LOCKOUT];
            end
            if (abort_evt)
            begin
                abort_flag_r <= 1'b1;
            end
            else if (wr_irq && bus.wdata[POS_ABORT])
            begin
                abort_flag_r <= 1'b0;
            end
            if (post_done && (halt_r || at_end))
            begin
                fin_flag_r <= 1'b1;
            end
            else if (wr_irq && bus.wdata[POS_FINISHED])
            begin
                fin_flag_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (wr_cmd)
        begin
            cmd_ram_r[bus.addr[5:2]] <= bus.wdata[5:0];
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i || !bus.rd)
        begin
            rdata_r <= 16'h0000;
        end
        else if (bus.addr == OFS_DLY)
        begin
            rdata_r <= {run_r, lead_r, post_r};
        end
        else if (bus.addr == OFS_WRAP)
        begin
            rdata_r <= {halt_r, wrap_en_r, wrap_tgt_r, cs_idle_r, end_ptr_r, done_ptr_r,
                        start_ptr_r};
        end
        else if (bus.addr == OFS_IRQ)
        begin
            rdata_r <= {3'h0, lockout_r, 9'h000, abort_flag_r, 1'b0, fin_flag_r};
        end
        else if (bus.addr == OFS_TXD)
        begin
            rdata_r <= {7'h00, !tx_ready, 8'h00};
        end
        else if (bus.addr == OFS_RXD)
        begin
            rdata_r <= rx_word_r;
        end
        else if (wr_cmd || bus.addr[7:6] == OFS_CMD_BASE[7:6])
        begin
            rdata_r <= {10'h000, cmd_ram_r[bus.addr[5:2]]};
        end
        else
        begin
            rdata_r <= 16'h0000;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        miso_m_r <= miso_i;
        miso_s_r <= miso_m_r;
    end

    // ==========================================================
    // sequencer
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            st_r       <= ST_IDLE;
            ptr_r      <= 4'h0;
            done_ptr_r <= 4'h0;
            dly_cnt_r  <= 8'h00;
        end
        else if (abort_evt)
        begin
            st_r <= ST_IDLE;
        end
        else
        begin
            unique case (st_r)
                ST_IDLE:
                begin
                    if (run_r)
                    begin
                        ptr_r <= start_ptr_r;
                        st_r  <= ST_LOAD;
                    end
                end
                ST_LOAD:
                begin
                    // an empty buffer stalls the queue with chip selects idle
                    if (tx_valid)
                    begin
                        dly_cnt_r <= lead_load;
                        st_r      <= ST_LEAD;
                    end
                end
                ST_LEAD:
                begin
                    if (dly_cnt_r <= 8'h01)
                    begin
                        st_r <= ST_SHIFT;
                    end
                    else
                    begin
                        dly_cnt_r <= dly_cnt_r - 8'h01;
                    end
                end
                ST_SHIFT:
                begin
                    if ((half_cnt_r == 4'h1) && (edge_cnt_r == SCK_EDGES - 6'h01))
                    begin
                        dly_cnt_r <= post_load;
                        st_r      <= ST_POST;
                    end
                end
                ST_POST:
                begin
                    if (post_done)
                    begin
                        done_ptr_r <= ptr_r;
                        if (seq_end)
                        begin
                            st_r <= ST_IDLE;
                        end
                        else if (at_end)
                        begin
                            ptr_r <= wrap_tgt_r ? start_ptr_r : 4'h0;
                            st_r  <= ST_LOAD;
                        end
                        else
                        begin
                            ptr_r <= ptr_r + 4'h1;
                            st_r  <= ST_LOAD;
                        end
                    end
                    else
                    begin
                        dly_cnt_r <= dly_cnt_r - 8'h01;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // serial shifter, mode 0: sample on rising, change on falling
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i || st_r != ST_SHIFT || abort_evt)
        begin
            sck_r      <= 1'b0;
            half_cnt_r <= SCK_HALF_CYC;
            edge_cnt_r <= 6'h00;
            if (tx_pop)
            begin
                sh_r   <= tx_data;
                mosi_r <= tx_data[15];
            end
        end
        else if (half_cnt_r == 4'h1)
        begin
            half_cnt_r <= SCK_HALF_CYC;
            sck_r      <= !sck_r;
            edge_cnt_r <= edge_cnt_r + 6'h01;
            if (!sck_r)
            begin
                rx_bit_r <= miso_s_r;
            end
            else
            begin
                sh_r   <= {sh_r[14:0], rx_bit_r};
                mosi_r <= sh_r[14];
                if (edge_cnt_r == SCK_EDGES - 6'h01)
                begin
                    rx_word_r <= {sh_r[14:0], rx_bit_r};
                end
            end
        end
        else
        begin
            half_cnt_r <= half_cnt_r - 4'h1;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            cs_r <= 4'h0;
        end
        else if ((st_r == ST_LEAD || st_r == ST_SHIFT) && !abort_evt)
        begin
            cs_r <= cur_cmd.cs;
        end
        else
        begin
            cs_r <= {4{cs_idle_r}};
        end
    end

    assign reg_rdata_o = rdata_r;
    assign sck_o       = sck_r;
    assign mosi_o      = mosi_r;
    assign cs_o        = cs_r;

    // ==========================================================
    // assertions
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    property p_start;
        (st_r == ST_IDLE && run_r && !abort_evt) |=> (st_r == ST_LOAD && ptr_r == $past(start_ptr_r));
    endproperty
    a_start: assert property (p_start) else $error("queue did not start at start pointer");

    property p_autoclr;
        (seq_end && !sw_set_run && !abort_evt) |=> (!run_r && st_r == ST_IDLE);
    endproperty
    a_autoclr: assert property (p_autoclr) else $error("run bit not cleared at end");

    property p_abort;
        abort_evt |=> (abort_flag_r && !run_r && st_r == ST_IDLE && cs_r == {4{$past(cs_idle_r)}});
    endproperty
    a_abort: assert property (p_abort) else $error("abort not taken");

    property p_lockout;
        (wr_dly && !bus.wdata[POS_RUN] && lockout_r && run_r) |=> (run_r || $past(seq_end));
    endproperty
    a_lockout: assert property (p_lockout) else $error("locked run bit was cleared");

    property p_lead;
        (st_r == ST_LOAD && tx_valid && !abort_evt && cur_cmd.clk_delay_select && lead_r > 7'h01)
            |=> (st_r == ST_LEAD && dly_cnt_r == {1'b0, $past(lead_r)})
                ##1 ($past(abort_evt) || (st_r == ST_LEAD && dly_cnt_r == $past(dly_cnt_r) - 8'h01));
    endproperty
    a_lead: assert property (p_lead) else $error("lead delay not counted");

    property p_post;
        (st_r == ST_SHIFT && half_cnt_r == 4'h1 && edge_cnt_r == SCK_EDGES - 6'h01 && !abort_evt
            && cur_cmd.post_delay_select && post_r != 8'h00)
            |=> (st_r == ST_POST && dly_cnt_r == $past(post_r));
    endproperty
    a_post: assert property (p_post) else $error("post delay not loaded");

    property p_halt;
        (post_done && halt_r && !abort_evt) |=> (st_r == ST_IDLE && fin_flag_r);
    endproperty
    a_halt: assert property (p_halt) else $error("halt did not stop queue");

    property p_wrap;
        (post_done && at_end && wrap_en_r && !halt_r && !abort_evt)
            |=> (st_r == ST_LOAD && fin_flag_r && ptr_r == ($past(wrap_tgt_r) ? $past(start_ptr_r) : 4'h0));
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap target wrong");

    property p_done_ptr;
        (post_done && !abort_evt) |=> (done_ptr_r == $past(ptr_r));
    endproperty
    a_done_ptr: assert property (p_done_ptr) else $error("done pointer not updated");

    property p_done_ro;
        (wr_wrap && !post_done) |=> (done_ptr_r == $past(done_ptr_r));
    endproperty
    a_done_ro: assert property (p_done_ro) else $error("done pointer written");

    property p_cs_idle;
        (st_r == ST_IDLE && $past(st_r) == ST_IDLE) |-> (cs_r == {4{$past(cs_idle_r, 1)}});
    endproperty
    a_cs_idle: assert property (p_cs_idle) else $error("idle chip select level wrong");

    c_wrap:  cover property (post_done && at_end && wrap_en_r && !halt_r);
    c_halt:  cover property (post_done && halt_r);
    c_abort: cover property (abort_evt && st_r == ST_SHIFT);
endmodule // qsc_seq
`default_nettype wire

//--- tb/qsc_peer.sv
// qsc_peer: serial peripheral at the chip selects, mode 0, 16-bit words.
// assumes sck idles low and all selects share one reply word.
`timescale 1ns/1ps
`default_nettype none
module qsc_peer
(
    input  wire logic        sck_i,
    input  wire logic        mosi_i,
    input  wire logic [3:0]  cs_i,
    input  wire logic        idle_i,
    input  wire logic [15:0] reply_i,
    output logic             miso_o
);
    // ==========================================================
    // capture and reply
    logic [15:0] sh_tx;
    logic [15:0] sh_rx;
    logic        sel;
    logic [3:0]  cs_q[$];
    logic [15:0] rx_q[$];
    assign sel = (cs_i != {4{idle_i}});
    initial miso_o = 1'b0;
    always @(posedge sel)
    begin
        sh_tx = reply_i;
        miso_o = reply_i[15];
        cs_q.push_back(cs_i);
    end
    // released line shows the inverse so stale data cannot pass
    always @(negedge sel)
    begin
        rx_q.push_back(sh_rx);
        miso_o = ~miso_o;
    end
    always @(posedge sck_i)
        if (sel) sh_rx = {sh_rx[14:0], mosi_i};
    always @(negedge sck_i)
        if (sel)
        begin
            sh_tx = {sh_tx[14:0], 1'b0};
            miso_o = sh_tx[15];
        end
endmodule // qsc_peer
`default_nettype wire

//--- tb/qsc_seq_tb.sv
// qsc_seq_tb: self-checking bench for the queue sequencer.
// assumes qsc_peer on the serial pins; registers at 40 MHz.
`timescale 1ns/1ps
`default_nettype none
module qsc_seq_tb
    import qsc_pkg::*;
;
    // ==========================================================
    // signals
    logic core_clk_i, srst_i, reg_wr, reg_rd, miso, sck, mosi, idle_lvl, sel_w, p_sel, p_sck;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, rdata, reply, rd_v, dly;
    logic [3:0]  cs;
    logic [3:0]  cmd_cs[16];
    logic [15:0] exp_q[$];
    logic [31:0] seed;
    int n_mismatch, n_checks, cyc, t_on, t_off, lead_cyc, gap_cyc, a_lead, a_gap;
    assign sel_w = (cs != {4{idle_lvl}});

    qsc_seq i_qsc_seq (.core_clk_i(core_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
        .miso_i(miso), .sck_o(sck), .mosi_o(mosi), .cs_o(cs));
    qsc_peer i_qsc_peer (.sck_i(sck), .mosi_i(mosi), .cs_i(cs), .idle_i(idle_lvl),
        .reply_i(reply), .miso_o(miso));

    initial
    begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end
    // ==========================================================
    // select-to-clock and select gap timing
    always @(posedge core_clk_i)
    begin
        cyc <= cyc + 1;
        p_sel <= sel_w;
        p_sck <= sck;
        if (sel_w && !p_sel) t_on <= cyc;
        if (sel_w && !p_sel) gap_cyc <= cyc - t_off;
        if (!sel_w && p_sel) t_off <= cyc;
        if (sck && !p_sck && cyc - t_on < 200) lead_cyc <= cyc - t_on;
    end
    initial
    begin
        repeat (60000) @(posedge core_clk_i);
        n_mismatch++;
        give_verdict();
    end
    // ==========================================================
    // tasks
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk_i);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk_i);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk_i);
        reg_rd <= 1'b0;
        #1 rd_v = rdata;
    endtask
    task automatic push(input int n);
        for (int k = 0; k < n; k++)
        begin
            seed = xs(seed);
            if (exp_q.size() < TX_DEPTH) exp_q.push_back(seed[15:0]);
            wr(OFS_TXD, seed[15:0]);
        end
    endtask
    task automatic go(input logic [3:0] st, input logic [3:0] en, input logic wp,
                      input logic tg, input int halt_at);
        logic [15:0] wv;
        wv = {1'b0, wp, tg, idle_lvl, en, 4'h0, st};
        wr(OFS_WRAP, wv);
        repeat (3) @(posedge core_clk_i);
        i_qsc_peer.cs_q.delete();
        i_qsc_peer.rx_q.delete();
        wr(OFS_DLY, dly);
        for (int k = 0; k < 9000 && i_qsc_peer.cs_q.size() < halt_at; k++)
            @(posedge core_clk_i);
        if (halt_at > 0) wr(OFS_WRAP, wv | 16'h8000);
        rd_v = 16'h8000;
        for (int k = 0; k < 5000 && rd_v[15]; k++) rd(OFS_DLY);
        chk("run_self_clear", 16'h0000, rd_v & 16'h8000);
        wr(OFS_WRAP, wv);
    endtask
    task automatic check_run(input logic [3:0] st, input logic [3:0] en, input logic tg,
                             input int n);
        logic [3:0] p;
        p = st;
        chk("entries", 16'(n), 16'(i_qsc_peer.cs_q.size()));
        for (int k = 0; k < n; k++)
        begin
            chk("cs", {12'h0, cmd_cs[p]}, {12'h0, i_qsc_peer.cs_q[k]});
            chk("mosi_word", exp_q.pop_front(), i_qsc_peer.rx_q[k]);
            if (k < n - 1) p = (p == en) ? (tg ? st : 4'h0) : p + 4'h1;
        end
        rd(OFS_WRAP);
        chk("done_ptr", {12'h0, p}, {12'h0, rd_v[7:4]});
        rd(OFS_IRQ);
        chk("finished", 16'h0001, rd_v & 16'h0005);
        wr(OFS_IRQ, 16'h0001);
        rd(OFS_IRQ);
        chk("finished_w1c", 16'h0000, rd_v);
        rd(OFS_RXD);
        chk("rx_word", reply, rd_v);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial
    begin
        {srst_i, seed, reply, dly} = {1'b1, 32'hab90, 32'h0};
        {cyc, t_on, t_off} = '0;
        {reg_wr, reg_rd, reg_addr, reg_wdata, idle_lvl, p_sel, p_sck} = '0;
        repeat (4) @(posedge core_clk_i);
        srst_i <= 1'b0;
        rd(OFS_DLY);
        chk("dly_reset", RST_DLY, rd_v);
        rd(OFS_WRAP);
        chk("wrap_reset", RST_WRAP, rd_v);
        rd(8'h20);
        chk("unmapped", 16'h0000, rd_v);
        chk("cs_idle_low", 16'h0000, {12'h0, cs});
        for (int i = 0; i < 16; i++)
        begin
            seed = xs(seed);
            cmd_cs[i] = 4'(seed % 14 + 1);
            wr(OFS_CMD_BASE + 8'(4 * i), {12'h0, cmd_cs[i]});
        end
        reply = seed[31:16];
        push(17);
        rd(OFS_TXD);
        chk("fifo_full", 16'h0100, rd_v & 16'h0100);
        dly = 16'h8101;
        go(4'h0, 4'hf, 1'b0, 1'b0, 0);
        check_run(4'h0, 4'hf, 1'b0, 16);
        wr(OFS_WRAP, 16'h0fa0);
        rd(OFS_WRAP);
        chk("done_ptr_ro", 16'h0ff0, rd_v);
        idle_lvl = 1'b1;
        wr(OFS_WRAP, 16'h1000);
        repeat (2) @(posedge core_clk_i);
        chk("cs_idle_high", 16'h000f, {12'h0, cs});
        push(3);
        go(4'h5, 4'h7, 1'b0, 1'b0, 0);
        check_run(4'h5, 4'h7, 1'b0, 3);
        for (int t = 0; t < 2; t++)
        begin
            push(3);
            go(4'h2, 4'h3, 1'b1, t[0], 3);
            check_run(4'h2, 4'h3, t[0], 3);
        end
        // delay bits on, then longer fields, then bits off with long fields
        for (int m = 0; m < 3; m++)
        begin
            for (int i = 0; i < 2; i++)
                wr(OFS_CMD_BASE + 8'(4 * i), {10'h0, (m < 2) ? 2'b11 : 2'b00, cmd_cs[i]});
            dly = (m == 0) ? 16'h8101 : 16'h9529;
            push(2);
            go(4'h0, 4'h1, 1'b0, 1'b0, 0);
            if (m == 0) {a_lead, a_gap} = {lead_cyc, gap_cyc};
            chk("lead_cycles", 16'(a_lead + ((m == 1) ? 20 : 0)), 16'(lead_cyc));
            chk("gap_cycles", 16'(a_gap + ((m == 1) ? 40 : 0)), 16'(gap_cyc));
            check_run(4'h0, 4'h1, 1'b0, 2);
        end
        // clear during a transfer, first locked out then free
        dly = 16'h8101;
        wr(OFS_IRQ, 16'h1000);
        wr(OFS_WRAP, 16'h1404);
        for (int m = 0; m < 2; m++)
        begin
            push(1);
            wr(OFS_DLY, dly);
            repeat (20) @(posedge core_clk_i);
            wr(OFS_DLY, 16'h0000);
            rd(OFS_DLY);
            chk("run_after_clear", (m == 0) ? 16'h8000 : 16'h0000, rd_v & 16'h8000);
            for (int k = 0; k < 500 && rd_v[15]; k++) rd(OFS_DLY);
            chk("cs_after_stop", 16'h000f, {12'h0, cs});
            rd(OFS_IRQ);
            chk("irq_flags", (m == 0) ? 16'h1001 : 16'h0004, rd_v);
            wr(OFS_IRQ, 16'h0001);
        end
        wr(OFS_IRQ, 16'h0000);
        rd(OFS_IRQ);
        chk("abort_w0", 16'h0004, rd_v);
        wr(OFS_IRQ, 16'h0004);
        rd(OFS_IRQ);
        chk("abort_w1c", 16'h0000, rd_v);
        give_verdict();
    end
endmodule // qsc_seq_tb
`default_nettype wire
